// File: design/fae_params.svh
// Constants of the flash converter back end: widths, bit positions, timing.
`ifndef FAE_PARAMS_SVH
`define FAE_PARAMS_SVH

// ==========================================================================
// Data path widths and bit positions
// ==========================================================================
`define FAE_THERM_W 63
`define FAE_WORD_W 6
`define FAE_MSB_POS 5
`define FAE_LOW_TOP 4
`define FAE_WORD_RST 6'h00

// ==========================================================================
// Clock and strobe timing
// ==========================================================================
`define FAE_CLK_NS 10
`define FAE_STO_NS 5
`define FAE_STO_CYC (((`FAE_STO_NS / `FAE_CLK_NS) < 1) ? 1 : \
  (`FAE_STO_NS / `FAE_CLK_NS))
`define FAE_PWL_NS 15
`define FAE_PWL_CYC ((`FAE_PWL_NS + `FAE_CLK_NS - 1) / `FAE_CLK_NS)
`define FAE_PWH_NS 17
`define FAE_PWH_CYC ((`FAE_PWH_NS + `FAE_CLK_NS - 1) / `FAE_CLK_NS)
`define FAE_MAX_MSPS 25
`define FAE_PER_NS (1000 / `FAE_MAX_MSPS)
`define FAE_PER_CYC ((`FAE_PER_NS + `FAE_CLK_NS - 1) / `FAE_CLK_NS)
`define FAE_CNT_W 8
`define FAE_CNT_MAX 8'hff

`endif

// File: design/fae_pkg.sv
// Types shared by the flash converter back end modules.
package fae_pkg;

  // ========================================================================
  // Format controls, both active low
  // ========================================================================
  typedef struct packed {
    logic top_bit_flip_n;
    logic low_bits_flip_n;
  } fae_fmt_t;

  // ========================================================================
  // Sticky strobe and configuration diagnostics
  // ========================================================================
  typedef struct packed {
    logic low_short;
    logic high_short;
    logic rate_high;
    logic fmt_moved;
  } fae_diag_t;

  // ========================================================================
  // Warm-up progress of the output register
  // ========================================================================
  typedef enum logic [1:0] {
    FAE_COLD,
    FAE_PRIMED,
    FAE_LIVE
  } fae_warm_t;

endpackage

// File: design/fae_therm_encoder.sv
// Thermometer to six-bit encoder with the four output formats.
`timescale 1ns/1ps
`include "fae_params.svh"

module fae_therm_encoder
  import fae_pkg::*;
(
  input wire logic [`FAE_THERM_W-1:0] therm,
  input wire fae_fmt_t fmt,
  output logic [`FAE_WORD_W-1:0] word
);

  logic [`FAE_WORD_W-1:0] ones;
  logic [`FAE_WORD_W-1:0] straight;

  // Counting ones instead of finding the top transition tolerates bubbles
  // and can never exceed 63, so off-scale inputs clamp at either end.
  always_comb begin
    ones = '0;
    for (int i = 0; i < `FAE_THERM_W; i++) begin
      ones = ones + `FAE_WORD_W'(therm[i]);
    end
  end

  // All comparators on means top of range, which is code zero.
  assign straight = ~ones;

  // Each active-low control flips its own group of bits.
  always_comb begin
    word = straight;
    word[`FAE_MSB_POS] = straight[`FAE_MSB_POS] ^ ~fmt.top_bit_flip_n;
    word[`FAE_LOW_TOP:0] = straight[`FAE_LOW_TOP:0]
      ^ {(`FAE_LOW_TOP + 1){~fmt.low_bits_flip_n}};
  end

endmodule // fae_therm_encoder

// File: design/fae_top.sv
// Digital back end of a six-bit flash converter: latch, encode, output.
`timescale 1ns/1ps
`include "fae_params.svh"

// Overview of operation
// - Latch all comparators on strobe rising edge.
// - Comparators form a 63-line thermometer code.
// - Encode 63 lines to 6 bits on falling edge.
// - Load output one rising edge after sampling.
// - Output holds steady between rising edges.
// - Six-bit word, most significant bit first.
// - True binary: top gives 0, bottom 63.
// - Off-scale inputs saturate, never wrap around.
// - Four formats chosen by two active-low controls.
// - Low top control inverts the top bit.
// - Low low-bits control inverts five lower bits.

module fae_top
  import fae_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sample_strobe,
  input wire logic [`FAE_THERM_W-1:0] comp_therm,
  input wire logic top_bit_flip_n,
  input wire logic low_bits_flip_n,
  output logic [`FAE_WORD_W-1:0] sample_out,
  output logic sample_valid,
  output fae_diag_t strobe_diag
);

  // ========================================================================
  // Input synchronisers
  // ========================================================================

  logic strobe_s1_reg;
  logic strobe_s2_reg;
  logic strobe_s3_reg;
  logic [`FAE_THERM_W-1:0] therm_s1_reg;
  logic [`FAE_THERM_W-1:0] therm_s2_reg;
  fae_fmt_t fmt_s1_reg;
  fae_fmt_t fmt_s2_reg;
  fae_fmt_t fmt_s3_reg;
  logic strobe_rise;
  logic strobe_fall;

  // The strobe, the comparator lines and the format pins all come from
  // outside this clock, so each goes through two flip-flops. Keeping the
  // same depth on strobe and comparators means the captured code is the
  // one present at the sampled strobe edge, one clock after the pin edge.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      strobe_s1_reg <= 1'b0;
      strobe_s2_reg <= 1'b0;
      strobe_s3_reg <= 1'b0;
    end else begin
      strobe_s1_reg <= sample_strobe;
      strobe_s2_reg <= strobe_s1_reg;
      strobe_s3_reg <= strobe_s2_reg;
    end
  end

  // Comparator lines are resampled every clock; this is the analog side.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      therm_s1_reg <= '0;
      therm_s2_reg <= '0;
    end else begin
      therm_s1_reg <= comp_therm;
      therm_s2_reg <= therm_s1_reg;
    end
  end

  // Format pins reset to true binary, both controls inactive.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fmt_s1_reg <= '1;
      fmt_s2_reg <= '1;
      fmt_s3_reg <= '1;
    end else begin
      fmt_s1_reg <= '{top_bit_flip_n: top_bit_flip_n,
                      low_bits_flip_n: low_bits_flip_n};
      fmt_s2_reg <= fmt_s1_reg;
      fmt_s3_reg <= fmt_s2_reg;
    end
  end

  // Edge detection looks only at the second and third stages.
  assign strobe_rise = strobe_s2_reg & ~strobe_s3_reg;
  assign strobe_fall = ~strobe_s2_reg & strobe_s3_reg;

  // ========================================================================
  // Sample, encode and output pipeline
  // ========================================================================

  logic [`FAE_THERM_W-1:0] therm_hold_reg;
  logic [`FAE_WORD_W-1:0] enc_word;
  logic [`FAE_WORD_W-1:0] enc_hold_reg;
  logic [`FAE_WORD_W-1:0] out_reg;

  // Comparator state is frozen on each rising strobe edge.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      therm_hold_reg <= '0;
    end else if (strobe_rise) begin
      therm_hold_reg <= therm_s2_reg;
    end
  end

  fae_therm_encoder u_enc (
    .therm(therm_hold_reg),
    .fmt(fmt_s2_reg),
    .word(enc_word)
  );

  // The encoded word is taken on the falling edge, so the format used is
  // whatever the pins showed one strobe high time after sampling.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      enc_hold_reg <= `FAE_WORD_RST;
    end else if (strobe_fall) begin
      enc_hold_reg <= enc_word;
    end
  end

  // The output moves only on a rising edge and holds otherwise.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_reg <= `FAE_WORD_RST;
    end else if (strobe_rise) begin
      out_reg <= enc_hold_reg;
    end
  end

  // Bit 5 is the most significant output line, bit 0 the least.
  assign sample_out = out_reg;

  // ========================================================================
  // Warm-up tracking
  // ========================================================================

  fae_warm_t warm_reg;
  logic valid_reg;

  // After reset the output still carries the reset word, not a sample.
  // The first rising edge takes a sample; the second one shows it.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      warm_reg <= FAE_COLD;
      valid_reg <= 1'b0;
    end else if (strobe_rise) begin
      unique case (warm_reg)
        FAE_COLD: begin
          warm_reg <= FAE_PRIMED;
        end
        FAE_PRIMED: begin
          warm_reg <= FAE_LIVE;
          valid_reg <= 1'b1;
        end
        FAE_LIVE: begin
          warm_reg <= FAE_LIVE;
        end
      endcase
    end
  end

  assign sample_valid = valid_reg;

  // ========================================================================
  // Strobe timing and configuration diagnostics
  // ========================================================================

  logic [`FAE_CNT_W-1:0] low_cnt_reg;
  logic [`FAE_CNT_W-1:0] high_cnt_reg;
  logic [`FAE_CNT_W-1:0] per_cnt_reg;
  logic primed_reg;
  logic [2:0] fmt_fill_reg;
  fae_diag_t diag_reg;

  // Widths are measured in whole clocks of the synchronised strobe, so a
  // legal pulse can read one clock short; each limit allows that slack.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt_reg <= '0;
      high_cnt_reg <= '0;
    end else begin
      if (strobe_s2_reg) begin
        low_cnt_reg <= '0;
      end else if (low_cnt_reg != `FAE_CNT_MAX) begin
        low_cnt_reg <= low_cnt_reg + 8'h01;
      end
      if (!strobe_s2_reg) begin
        high_cnt_reg <= '0;
      end else if (high_cnt_reg != `FAE_CNT_MAX) begin
        high_cnt_reg <= high_cnt_reg + 8'h01;
      end
    end
  end

  // Period count between rising edges; the first edge only arms it.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      per_cnt_reg <= '0;
      primed_reg <= 1'b0;
    end else if (strobe_rise) begin
      per_cnt_reg <= 8'h01;
      primed_reg <= 1'b1;
    end else if (per_cnt_reg != `FAE_CNT_MAX) begin
      per_cnt_reg <= per_cnt_reg + 8'h01;
    end
  end

  // The format stages reset to the inactive level, which a pin tied low
  // does not match; comparing them before real pin values have filled all
  // three would flag a change that never happened on the pins.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fmt_fill_reg <= 3'h0;
    end else begin
      fmt_fill_reg <= {fmt_fill_reg[1:0], 1'b1};
    end
  end

  // Flags are sticky until reset; nothing else clears them, so no set can
  // be lost against a clear.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      diag_reg <= '0;
    end else begin
      if (strobe_rise && primed_reg &&
          (low_cnt_reg + 8'h01 < 8'(`FAE_PWL_CYC))) begin
        diag_reg.low_short <= 1'b1;
      end
      if (strobe_fall && (high_cnt_reg + 8'h01 < 8'(`FAE_PWH_CYC))) begin
        diag_reg.high_short <= 1'b1;
      end
      if (strobe_rise && primed_reg &&
          (per_cnt_reg + 8'h01 < 8'(`FAE_PER_CYC))) begin
        diag_reg.rate_high <= 1'b1;
      end
      if (fmt_fill_reg[2] && (fmt_s2_reg != fmt_s3_reg)) begin
        diag_reg.fmt_moved <= 1'b1;
      end
    end
  end

  assign strobe_diag = diag_reg;

endmodule // fae_top

// File: dv/fae_top_props.sv
// Port-level assertions for the flash converter back end.
`timescale 1ns/1ps
`include "fae_params.svh"
module fae_top_props
  import fae_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sample_strobe,
  input wire logic [`FAE_THERM_W-1:0] comp_therm,
  input wire logic top_bit_flip_n,
  input wire logic low_bits_flip_n,
  input wire logic [`FAE_WORD_W-1:0] sample_out,
  input wire logic sample_valid,
  input wire fae_diag_t strobe_diag
);
  logic strobe_reg;
  logic [4:0] rise_reg;
  logic [1:0] rises_reg;

  // Pin rise history; the window covers the two-stage synchroniser slack.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      strobe_reg <= 1'b0;
      rise_reg <= 5'h00;
      rises_reg <= 2'h0;
    end else begin
      strobe_reg <= sample_strobe;
      rise_reg <= {rise_reg[3:0], sample_strobe & ~strobe_reg};
      if (sample_strobe && !strobe_reg && rises_reg != 2'h3) begin
        rises_reg <= rises_reg + 2'h1;
      end
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence rise_seen;
    |rise_reg[4:1];
  endsequence
  sequence two_rises;
    rises_reg >= 2'h2;
  endsequence
  property valid_start;
    $rose(sample_valid) |-> two_rises ##0 rise_seen;
  endproperty

  a_out_timing: assert property ($changed(sample_out) |-> rise_seen)
    else $error("sample word moved without a strobe rise");
  a_out_settle: assert property ($changed(sample_out) |=> $stable(sample_out))
    else $error("sample word moved on two cycles in a row");
  a_valid_start: assert property (valid_start)
    else $error("valid raised before the second strobe rise");
  a_valid_hold: assert property (sample_valid |=> sample_valid)
    else $error("valid dropped without reset");
  a_diag_sticky: assert property (1'b1 |=>
    (strobe_diag & $past(strobe_diag)) == $past(strobe_diag))
    else $error("diagnostic flag cleared without reset");
  a_fmt_flag: assert property ($changed({top_bit_flip_n, low_bits_flip_n})
    |-> ##[1:6] strobe_diag[0])
    else $error("format change not flagged");
  a_rate_flag: assert property (rise_reg[0] && rise_reg[2] &&
    rises_reg == 2'h3 |-> ##[1:6] strobe_diag[1])
    else $error("fast strobe not flagged");
  a_reset_clear: assert property (disable iff (1'b0) sys_rst &&
    $past(sys_rst) |-> sample_out == 6'h00 && !sample_valid &&
    strobe_diag == '0)
    else $error("outputs not cleared in reset");
endmodule // fae_top_props

bind fae_top fae_top_props fae_top_props_i (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .sample_strobe(sample_strobe),
  .comp_therm(comp_therm),
  .top_bit_flip_n(top_bit_flip_n),
  .low_bits_flip_n(low_bits_flip_n),
  .sample_out(sample_out),
  .sample_valid(sample_valid),
  .strobe_diag(strobe_diag)
);

// File: dv/fae_capture_model.sv
// Capture-side model: makes the convert strobe and the comparator lines.
`timescale 1ns/1ps
`include "fae_params.svh"
module fae_capture_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic [3:0] hi_cyc,
  input wire logic [3:0] lo_cyc,
  input wire logic [5:0] level,
  output logic sample_strobe = 1'b0,
  output logic [`FAE_THERM_W-1:0] comp_therm = '0,
  output logic rise = 1'b0
);
  logic [3:0] cnt_reg = 4'h0;

  // A period always completes, so stopping never leaves a short pulse.
  always_ff @(posedge mclk) begin
    rise <= 1'b0;
    if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else if (sample_strobe) begin
      sample_strobe <= 1'b0;
      cnt_reg <= lo_cyc - 4'h1;
    end else if (go) begin
      sample_strobe <= 1'b1;
      comp_therm <= ~({`FAE_THERM_W{1'b1}} << level);
      cnt_reg <= hi_cyc - 4'h1;
      rise <= 1'b1;
    end
  end
endmodule // fae_capture_model

// File: dv/fae_top_tb_top.sv
// Self-checking bench for the flash converter back end.
`timescale 1ns/1ps
`include "fae_params.svh"
module fae_top_tb_top
  import fae_pkg::*;
;
  logic mclk, sys_rst, go, rise, chk_en;
  logic top_bit_flip_n, low_bits_flip_n, sample_strobe, sample_valid;
  logic [`FAE_THERM_W-1:0] comp_therm;
  logic [5:0] sample_out, level;
  logic [3:0] hi_cyc, lo_cyc;
  logic [31:0] seed;
  fae_diag_t strobe_diag;
  int fails, checks, nrise, nlvl;
  int exp_w[$];

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  fae_top fae_top_i (.mclk(mclk), .sys_rst(sys_rst),
    .sample_strobe(sample_strobe), .comp_therm(comp_therm),
    .top_bit_flip_n(top_bit_flip_n), .low_bits_flip_n(low_bits_flip_n),
    .sample_out(sample_out), .sample_valid(sample_valid),
    .strobe_diag(strobe_diag));
  fae_capture_model fae_capture_model_i (.mclk(mclk), .go(go),
    .hi_cyc(hi_cyc), .lo_cyc(lo_cyc), .level(level),
    .sample_strobe(sample_strobe), .comp_therm(comp_therm), .rise(rise));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask

  // The word on show trails the newest sample by back-1 strobe periods.
  task automatic check_word(input int back);
    int n;
    n = exp_w.size();
    cmp({15'h0, sample_valid}, {15'h0, n >= back});
    if (n >= back) cmp({10'h0, sample_out}, 16'(exp_w[n - back]));
  endtask

  task automatic burst(input int n, input logic [3:0] hi, input logic [3:0] lo);
    int target;
    target = nrise + n;
    @(posedge mclk);
    hi_cyc <= hi;
    lo_cyc <= lo;
    go <= 1'b1;
    for (int i = 0; i < 400 && nrise < target; i++) @(posedge mclk);
    go <= 1'b0;
    if (nrise < target) fails++;
    repeat (10) @(posedge mclk);
  endtask

  task automatic print_verdict();
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Reference model: one expected word per strobe rise, ends of range first.
  always @(posedge mclk) begin
    #1;
    if (rise === 1'b1) begin
      nrise++;
      exp_w.push_back((63 - level) ^ (top_bit_flip_n ? 0 : 32) ^
        (low_bits_flip_n ? 0 : 31));
      if (chk_en) check_word(3);
      nlvl++;
      seed = lfsr_next(seed);
      level = (nlvl == 1) ? 6'h3f : seed[5:0];
    end
  end

  // Watchdog; the whole run needs well under a thousand cycles.
  initial begin
    #20000;
    fails++;
    $display("unexpected at %0t: run did not finish", $time);
    print_verdict();
  end

  // Main sequence: all formats, a fast strobe, then a reset in mid-run.
  initial begin
    sys_rst = 1'b1;
    go = 1'b0;
    chk_en = 1'b1;
    hi_cyc = 4'h2;
    lo_cyc = 4'h2;
    level = 6'h00;
    top_bit_flip_n = 1'b1;
    low_bits_flip_n = 1'b1;
    seed = 32'h2f2e;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int f = 3; f >= 0; f--) begin
      @(posedge mclk);
      {top_bit_flip_n, low_bits_flip_n} <= f[1:0];
      repeat (6) @(posedge mclk);
      burst(8, 4'h2, 4'h2);
      check_word(2);
      if (f == 3) cmp({12'h0, strobe_diag}, 16'h0000);
    end
    cmp({12'h0, strobe_diag}, 16'h0001);
    chk_en = 1'b0;
    burst(4, 4'h1, 4'h1);
    cmp({12'h0, strobe_diag}, 16'h0003);
    sys_rst <= 1'b1;
    repeat (16) @(posedge mclk);
    cmp({5'h0, sample_out, sample_valid, strobe_diag}, 16'h0000);
    exp_w.delete();
    chk_en = 1'b1;
    sys_rst <= 1'b0;
    burst(5, 4'h2, 4'h2);
    check_word(2);
    cmp({12'h0, strobe_diag}, 16'h0000);
    print_verdict();
  end
endmodule // fae_top_tb_top
